/* hdl/sdmmc_events_pkg.sv */
// constants for the sd/mmc bus-side event, fifo, card-detect and dma logic
package sdmmc_events_pkg;
	// register byte offsets
	localparam logic [11:0] CTRL_OFS        = 12'h000;
	localparam logic [11:0] TIMEOUT_OFS     = 12'h014;
	localparam logic [11:0] INT_MASK_OFS    = 12'h024;
	localparam logic [11:0] RAW_INT_OFS     = 12'h044;
	localparam logic [11:0] FIFO_STATUS_OFS = 12'h048;
	localparam logic [11:0] FIFO_THRESH_OFS = 12'h04c;
	localparam logic [11:0] CARD_DET_OFS    = 12'h050;
	localparam logic [11:0] DEBOUNCE_OFS    = 12'h064;
	localparam logic [11:0] DATA_FIFO_OFS   = 12'h200;
	// control register fields
	localparam int CTRL_INT_EN_BIT  = 4;
	localparam int CTRL_DMA_EN_BIT  = 5;
	// field positions
	localparam int TIMEOUT_LSB      = 8;
	localparam int TX_WM_LSB        = 0;
	localparam int RX_WM_LSB        = 16;
	localparam int WM_W             = 12;
	localparam int FIFO_COUNT_LSB   = 17;
	localparam int DEBOUNCE_W       = 24;
	// raw interrupt status bit positions
	localparam int CARD_DETECT_CHANGE  = 0;
	localparam int RESPONSE_ERROR      = 1;
	localparam int COMMAND_DONE_FLAG   = 2;
	localparam int DATA_TRANSFER_OVER  = 3;
	localparam int TX_FIFO_REQUEST     = 4;
	localparam int RX_FIFO_REQUEST     = 5;
	localparam int RESPONSE_CRC_ERROR  = 6;
	localparam int DATA_CRC_ERROR      = 7;
	localparam int RESPONSE_TIMEOUT    = 8;
	localparam int DATA_READ_TIMEOUT   = 9;
	localparam int HOST_STARVE_TIMEOUT = 10;
	localparam int NUM_EVENTS          = 11;
	// reset values
	localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
	localparam logic [31:0] INT_MASK_RST = 32'h0000_0000;
	localparam logic [31:0] TIMEOUT_RST  = 32'hffff_ff00;
	localparam logic [31:0] THRESH_RST   = 32'h0007_0008;
	localparam logic [31:0] DEBOUNCE_RST = 32'h00ff_ffff;
endpackage

/* hdl/sdmmc_bus_events.sv */
// bus-side events, dual-clock data fifo, card detect and dma request of an sd/mmc host
//
// Notes on behaviour
// - halt card clock when fifo empty on card write or full on card read
// - on each halt load starvation counter with data timeout; expiry sets starvation flag
// - clock stays halted after timeout; host push or pop restarts it
// - data read timeout also sets data transfer over
// - response timeout sets command done; data transfer is then skipped
// - data crc mismatch sets data crc error
// - response crc mismatch sets response crc error
// - receive request is set while fill above receive threshold on reads
// - transmit request while fill at or below transmit threshold on writes
// - transfer over set at end of transfer even with errors or busy
// - command done set after response even when response is bad
// - response error on transmission bit, index mismatch or end bit zero
// - card insert or removal sets detect change; state register shows presence
// - fifo is dual-port ram, one port per clock, synchronous both sides
// - presence inputs debounced by programmable filter, one event per change
// - simultaneous changes give one event; software xors with stored copy
// - dma request on reads above rx watermark, writes at or below tx watermark
// - dma handshake only for data; plain bus fifo accesses still accepted
// - raw status bits stay set until written with one
// - interrupt is registered level of raw and mask and global enable
// - global enable and masks reset to zero
`timescale 1ns/100ps
module sdmmc_bus_events #(
	parameter int ADDR_W = 4,
	parameter int DATA_W = 32,
	parameter int NCARDS = 1
) (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [11:0]       reg_addr,
	input  wire logic [31:0]       reg_wdata,
	output logic      [31:0]       reg_rdata,
	output logic                   int_out,
	output logic                   dma_req,
	input  wire logic [NCARDS-1:0] card_present_n,
	input  wire logic              cclk,
	input  wire logic              xfer_active,
	input  wire logic              xfer_write,
	input  wire logic              cmd_done_evt,
	input  wire logic              cmd_has_data,
	input  wire logic              resp_done,
	input  wire logic              resp_tx_bit,
	input  wire logic              resp_end_bit,
	input  wire logic              resp_check_index,
	input  wire logic [5:0]        resp_index,
	input  wire logic [5:0]        sent_index,
	input  wire logic              resp_crc_bad,
	input  wire logic              resp_timeout_evt,
	input  wire logic              data_done_evt,
	input  wire logic              data_crc_bad,
	input  wire logic              data_read_timeout_evt,
	input  wire logic              card_push,
	input  wire logic [DATA_W-1:0] card_wdata,
	input  wire logic              card_pop,
	output logic      [DATA_W-1:0] card_rdata,
	output logic                   card_fifo_empty,
	output logic                   card_fifo_full,
	output logic                   card_clk_stop,
	output logic                   skip_data
);
	localparam int DEPTH = 1 << ADDR_W;
	localparam int PW    = ADDR_W + 1;

	if (ADDR_W < 2 || ADDR_W > 11 || DATA_W != 32 || NCARDS < 1 || NCARDS > 32) begin : g_chk
		$error("sdmmc_bus_events: unsupported parameter values");
	end

	function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
		logic [PW-1:0] b;
		b = '0;
		for (int i = PW - 1; i >= 0; i--) begin
			b[i] = (i == PW - 1) ? g[i] : (b[i+1] ^ g[i]);
		end
		return b;
	endfunction

	// registers and memories of the host and card clock domains
	logic [31:0]            ctrl_q, mask_q, tmo_q, thr_q, deb_q, raw_q, raw_d, rdata_q;
	logic                   int_q, dma_q;
	logic [DATA_W-1:0]      c2h_mem [DEPTH];
	logic [DATA_W-1:0]      h2c_mem [DEPTH];
	logic [PW-1:0]          hptr_q, hgray_q, cptr_q, cgray_q;
	logic [PW-1:0]          cg_s1_q, cg_s2_q, hg_s1_q, hg_s2_q;
	logic [PW-1:0]          cptr_h, hptr_c, fill, cptr_d;
	logic [DATA_W-1:0]      crdata_q;
	logic                   crst1_q, crst_q, cempty_q, cfull_q, cstop_q, skip_q;
	logic [sdmmc_events_pkg::NUM_EVENTS-1:0] tog_q, tog1_q, tog2_q, tog3_q, card_ev, host_ev;
	logic                   act1_q, act_q, wr1_q, wr_q, stop1_q, stop_q;
	logic [23:0]            starve_q;
	logic                   starve_run_q;
	logic [NCARDS-1:0]      cd1_q, cd2_q, cd_stable_q;
	logic [sdmmc_events_pkg::DEBOUNCE_W-1:0] deb_cnt_q;
	logic                   cdt_pulse, hto_pulse, rx_cond, tx_cond, hpush, hpop, hfull, hempty;
	logic                   rd_fifo_sel, wr_fifo_sel, c_push, c_pop;

	// register decode
	assign rd_fifo_sel = reg_addr >= sdmmc_events_pkg::DATA_FIFO_OFS;
	assign wr_fifo_sel = rd_fifo_sel;
	assign hpush = reg_wr && wr_fifo_sel && !hfull;
	assign hpop  = reg_rd && rd_fifo_sel && !hempty;

	// card-domain reset taken from the host reset through two flops
	always_ff @(posedge cclk) begin
		crst1_q <= srst;
		crst_q  <= crst1_q;
	end

	// card-side event vector: each event becomes a toggle for the host domain
	always_comb begin
		card_ev = '0;
		card_ev[sdmmc_events_pkg::RESPONSE_ERROR] = resp_done && (resp_tx_bit || !resp_end_bit
			|| (resp_check_index && resp_index != sent_index));
		card_ev[sdmmc_events_pkg::COMMAND_DONE_FLAG]  = cmd_done_evt || resp_timeout_evt;
		card_ev[sdmmc_events_pkg::DATA_TRANSFER_OVER] = data_done_evt || data_read_timeout_evt;
		card_ev[sdmmc_events_pkg::RESPONSE_CRC_ERROR] = resp_done && resp_crc_bad;
		card_ev[sdmmc_events_pkg::DATA_CRC_ERROR]     = data_crc_bad;
		card_ev[sdmmc_events_pkg::RESPONSE_TIMEOUT]   = resp_timeout_evt;
		card_ev[sdmmc_events_pkg::DATA_READ_TIMEOUT]  = data_read_timeout_evt;
	end

	always_ff @(posedge cclk) begin
		if (crst_q) begin
			tog_q <= '0;
		end else begin
			tog_q <= tog_q ^ card_ev;
		end
	end

	// toggle synchroniser into host domain, edge found past the second flop
	always_ff @(posedge clk) begin
		if (srst) begin
			{tog1_q, tog2_q, tog3_q} <= '0;
		end else begin
			tog1_q <= tog_q;
			tog2_q <= tog1_q;
			tog3_q <= tog2_q;
		end
	end
	assign host_ev = tog2_q ^ tog3_q;

	// response timeout tells the data path not to start
	always_ff @(posedge cclk) begin
		if (crst_q) begin
			skip_q <= 1'b0;
		end else begin
			skip_q <= resp_timeout_evt && cmd_has_data;
		end
	end

	// card port of the fifo; flags follow the pointer after this edge so no extra word slips in
	assign c_push = card_push && !xfer_write && !cfull_q;
	assign c_pop  = card_pop && xfer_write && !cempty_q;
	assign cptr_d = cptr_q + PW'(c_push || c_pop);
	assign hptr_c = gray2bin(hg_s2_q);
	always_ff @(posedge cclk) begin
		if (c_push) begin
			c2h_mem[cptr_q[ADDR_W-1:0]] <= card_wdata;
		end
		if (c_pop) begin
			crdata_q <= h2c_mem[cptr_q[ADDR_W-1:0]];
		end
	end
	// card pointer, synchronised host pointer and the card-side flags
	always_ff @(posedge cclk) begin
		if (crst_q) begin
			{cptr_q, cgray_q, hg_s1_q, hg_s2_q, cfull_q, cstop_q} <= '0;
			cempty_q <= 1'b1;
		end else begin
			hg_s1_q  <= hgray_q;
			hg_s2_q  <= hg_s1_q;
			cptr_q   <= cptr_d;
			cgray_q  <= cptr_d ^ (cptr_d >> 1);
			cempty_q <= xfer_write && (hptr_c == cptr_d);
			cfull_q  <= !xfer_write && (PW'(cptr_d - hptr_c) >= PW'(DEPTH));
			cstop_q  <= xfer_active && (xfer_write ? (hptr_c == cptr_d)
				: (PW'(cptr_d - hptr_c) >= PW'(DEPTH)));
		end
	end
	// host port of the fifo
	always_ff @(posedge clk) begin
		if (hpush) begin
			h2c_mem[hptr_q[ADDR_W-1:0]] <= reg_wdata;
		end
	end

	assign cptr_h = gray2bin(cg_s2_q);
	assign fill   = wr_q ? PW'(hptr_q - cptr_h) : PW'(cptr_h - hptr_q);
	assign hfull  = !wr_q || fill >= PW'(DEPTH);
	assign hempty = wr_q || fill == '0;

	always_ff @(posedge clk) begin
		if (srst) begin
			{hptr_q, hgray_q, cg_s1_q, cg_s2_q} <= '0;
		end else begin
			cg_s1_q <= cgray_q;
			cg_s2_q <= cg_s1_q;
			if (hpush || hpop) begin
				hptr_q  <= hptr_q + 1'b1;
				hgray_q <= (hptr_q + 1'b1) ^ ((hptr_q + 1'b1) >> 1);
			end
		end
	end

	// transfer direction and clock halt brought into host domain
	always_ff @(posedge clk) begin
		if (srst) begin
			{act1_q, act_q, wr1_q, wr_q, stop1_q, stop_q} <= '0;
		end else begin
			act1_q  <= xfer_active;
			act_q   <= act1_q;
			wr1_q   <= xfer_write;
			wr_q    <= wr1_q;
			stop1_q <= cstop_q;
			stop_q  <= stop1_q;
		end
	end

	// starvation counter runs only while the card clock is halted
	always_ff @(posedge clk) begin
		if (srst || !stop_q) begin
			starve_q     <= '0;
			starve_run_q <= 1'b0;
		end else if (!starve_run_q) begin
			starve_q     <= tmo_q[31:sdmmc_events_pkg::TIMEOUT_LSB];
			starve_run_q <= 1'b1;
		end else if (starve_q != '0) begin
			starve_q <= starve_q - 1'b1;
		end
	end
	assign hto_pulse = starve_run_q && stop_q && starve_q == 24'h00_0001;
	// watermark levels, compared at full width so a large watermark is not cut short
	assign rx_cond = act_q && !wr_q
		&& 32'(fill) > 32'(thr_q[sdmmc_events_pkg::RX_WM_LSB +: sdmmc_events_pkg::WM_W]);
	assign tx_cond = act_q && wr_q
		&& 32'(fill) <= 32'(thr_q[sdmmc_events_pkg::TX_WM_LSB +: sdmmc_events_pkg::WM_W]);

	// card detect: two-flop sync then debounce filter
	always_ff @(posedge clk) begin
		if (srst) begin
			{cd1_q, cd2_q, cd_stable_q, deb_cnt_q} <= '0;
		end else begin
			cd1_q <= ~card_present_n;
			cd2_q <= cd1_q;
			if (cd2_q == cd_stable_q) begin
				deb_cnt_q <= '0;
			end else if (deb_cnt_q >= deb_q[sdmmc_events_pkg::DEBOUNCE_W-1:0]) begin
				cd_stable_q <= cd2_q;
				deb_cnt_q   <= '0;
			end else begin
				deb_cnt_q <= deb_cnt_q + 1'b1;
			end
		end
	end
	assign cdt_pulse = cd2_q != cd_stable_q && deb_cnt_q >= deb_q[sdmmc_events_pkg::DEBOUNCE_W-1:0];
	// raw status: hardware set wins over software clear
	always_comb begin
		raw_d = raw_q;
		if (reg_wr && reg_addr == sdmmc_events_pkg::RAW_INT_OFS) begin
			raw_d = raw_q & ~reg_wdata;
		end
		raw_d[sdmmc_events_pkg::NUM_EVENTS-1:0] = raw_d[sdmmc_events_pkg::NUM_EVENTS-1:0] | host_ev;
		raw_d[sdmmc_events_pkg::CARD_DETECT_CHANGE]  |= cdt_pulse;
		raw_d[sdmmc_events_pkg::HOST_STARVE_TIMEOUT] |= hto_pulse;
		raw_d[sdmmc_events_pkg::RX_FIFO_REQUEST]     |= rx_cond;
		raw_d[sdmmc_events_pkg::TX_FIFO_REQUEST]     |= tx_cond;
		raw_d[31:sdmmc_events_pkg::NUM_EVENTS] = '0;
	end

	// software registers
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= sdmmc_events_pkg::CTRL_RST;
			mask_q <= sdmmc_events_pkg::INT_MASK_RST;
			tmo_q  <= sdmmc_events_pkg::TIMEOUT_RST;
			thr_q  <= sdmmc_events_pkg::THRESH_RST;
			deb_q  <= sdmmc_events_pkg::DEBOUNCE_RST;
			raw_q  <= '0;
		end else begin
			raw_q <= raw_d;
			if (reg_wr) begin
				unique case (reg_addr)
					sdmmc_events_pkg::CTRL_OFS:        ctrl_q <= reg_wdata;
					sdmmc_events_pkg::INT_MASK_OFS:    mask_q <= reg_wdata;
					sdmmc_events_pkg::TIMEOUT_OFS:     tmo_q  <= reg_wdata;
					sdmmc_events_pkg::FIFO_THRESH_OFS: thr_q  <= reg_wdata;
					sdmmc_events_pkg::DEBOUNCE_OFS:    deb_q  <= reg_wdata;
					default: ;
				endcase
			end
		end
	end

	// read data, interrupt and dma request, all registered
	always_ff @(posedge clk) begin
		if (srst) begin
			{rdata_q, int_q, dma_q} <= '0;
		end else begin
			int_q <= ctrl_q[sdmmc_events_pkg::CTRL_INT_EN_BIT] && |(raw_q & mask_q);
			dma_q <= ctrl_q[sdmmc_events_pkg::CTRL_DMA_EN_BIT] && (rx_cond || tx_cond);
			if (hpop) begin
				rdata_q <= c2h_mem[hptr_q[ADDR_W-1:0]];
			end else if (reg_rd) begin
				unique case (reg_addr)
					sdmmc_events_pkg::CTRL_OFS:        rdata_q <= ctrl_q;
					sdmmc_events_pkg::INT_MASK_OFS:    rdata_q <= mask_q;
					sdmmc_events_pkg::TIMEOUT_OFS:     rdata_q <= tmo_q;
					sdmmc_events_pkg::FIFO_THRESH_OFS: rdata_q <= thr_q;
					sdmmc_events_pkg::DEBOUNCE_OFS:    rdata_q <= deb_q;
					sdmmc_events_pkg::RAW_INT_OFS:     rdata_q <= raw_q;
					sdmmc_events_pkg::CARD_DET_OFS:    rdata_q <= 32'(cd_stable_q);
					sdmmc_events_pkg::FIFO_STATUS_OFS: rdata_q <= 32'(fill) << sdmmc_events_pkg::FIFO_COUNT_LSB;
					default:                           rdata_q <= '0;
				endcase
			end
		end
	end

	assign reg_rdata       = rdata_q;
	assign int_out         = int_q;
	assign dma_req         = dma_q;
	assign card_rdata      = crdata_q;
	assign card_fifo_empty = cempty_q;
	assign card_fifo_full  = cfull_q;
	assign card_clk_stop   = cstop_q;
	assign skip_data       = skip_q;
	// checks
	sequence s_halt_seen;
		stop_q && !starve_run_q;
	endsequence
	sequence s_loaded;
		##1 starve_run_q && starve_q == tmo_q[31:8];
	endsequence
	a_starve_load: assert property (@(posedge clk) disable iff (srst)
		s_halt_seen |-> s_loaded) else $error("starvation counter not loaded");
	a_starve_clear: assert property (@(posedge clk) disable iff (srst)
		!stop_q |=> starve_q == '0 && !starve_run_q) else $error("starvation counter not cleared");
	a_halt_write: assert property (@(posedge cclk) disable iff (crst_q)
		xfer_active && xfer_write && hptr_c == cptr_q |=> cstop_q) else $error("no halt on empty");
	a_skip_data: assert property (@(posedge cclk) disable iff (crst_q)
		resp_timeout_evt && cmd_has_data |=> skip_q) else $error("data not skipped");
	a_raw_sticky: assert property (@(posedge clk) disable iff (srst)
		raw_q[2] && !(reg_wr && reg_addr == 12'h044 && reg_wdata[2]) |=> raw_q[2]) else $error("raw bit lost");
	a_int_level: assert property (@(posedge clk) disable iff (srst)
		##1 int_out == $past(ctrl_q[4] && |(raw_q & mask_q))) else $error("interrupt level wrong");
	a_rx_level: assert property (@(posedge clk) disable iff (srst)
		rx_cond |=> raw_q[5]) else $error("rx request not set");
	a_tx_level: assert property (@(posedge clk) disable iff (srst)
		tx_cond |=> raw_q[4]) else $error("tx request not set");
	a_event_cross: assert property (@(posedge clk) disable iff (srst)
		host_ev[8] |=> raw_q[8]) else $error("timeout event lost");
	a_dma_req: assert property (@(posedge clk) disable iff (srst)
		ctrl_q[5] && (rx_cond || tx_cond) |=> dma_req) else $error("dma request missing");
	a_detect_once: assert property (@(posedge clk) disable iff (srst)
		cdt_pulse |=> !cdt_pulse && cd_stable_q == $past(cd2_q)) else $error("detect change repeated");
endmodule

/* tb/card_side_model.sv */
// behavioural card-side partner that drives the card-domain inputs of the event block
`timescale 1ns/100ps
module card_side_model (
	input  wire logic        cclk,
	input  wire logic        card_fifo_empty,
	input  wire logic        card_fifo_full,
	input  wire logic        card_clk_stop,
	input  wire logic        skip_data,
	input  wire logic [31:0] card_rdata,
	output logic             xfer_active,
	output logic             xfer_write,
	output logic             card_push,
	output logic             card_pop,
	output logic      [31:0] card_wdata,
	output logic      [11:0] ev
);
	logic [15:0] nxt = 16'h0000;
	logic        pop_d = 1'b0;
	logic        skip_seen = 1'b0;
	logic [31:0] rx_q[$];

	// pushed words carry a running index so the host can tell order and loss
	assign card_wdata = {16'ha5a5, nxt};

	initial begin
		xfer_active = 1'b0;
		xfer_write = 1'b0;
		card_push = 1'b0;
		card_pop = 1'b0;
		ev = 12'h000;
	end

	// accepted pushes advance the pattern; popped data is taken one cycle later
	always @(posedge cclk) begin
		if (card_push && !card_fifo_full)
			nxt <= nxt + 16'h0001;
		if (pop_d)
			rx_q.push_back(card_rdata);
		pop_d <= card_pop && !card_fifo_empty;
		if (skip_data)
			skip_seen <= 1'b1;
	end

	// one event pulse, then quiet cycles so the toggle crossing keeps up
	task automatic pulse(input logic [11:0] s);
		skip_seen = 1'b0;
		@(posedge cclk);
		#1 ev = s;
		@(posedge cclk);
		#1 ev = 12'h000;
		repeat (2) @(posedge cclk);
	endtask

	// only one data transfer is open at a time, and no card reset is sent inside one
	task automatic xfer(input logic a, input logic w);
		@(posedge cclk);
		#1 xfer_active = a;
		xfer_write = w;
		repeat (3) @(posedge cclk);
	endtask

	// moves data whenever the fifo allows and the card clock runs
	task automatic stream(input logic wr, input int cyc);
		repeat (cyc) begin
			@(posedge cclk);
			#1 card_push = !wr && !card_fifo_full && !card_clk_stop;
			card_pop = wr && !card_fifo_empty && !card_clk_stop;
		end
		@(posedge cclk);
		#1 card_push = 1'b0;
		card_pop = 1'b0;
	endtask
endmodule

/* tb/tb_sdmmc_bus_events.sv */
// self-checking bench for the bus-side event, fifo, card-detect and dma logic
`timescale 1ns/100ps
module tb_sdmmc_bus_events;
	logic        clk = 1'b0;
	logic        cclk = 1'b0;
	logic        srst = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [0:0]  card_present_n = 1'b1;
	logic [31:0] reg_rdata, card_rdata, card_wdata, d;
	logic        int_out, dma_req, xfer_active, xfer_write, card_push, card_pop;
	logic        card_fifo_empty, card_fifo_full, card_clk_stop, skip_data;
	logic [11:0] ev;
	int          err_total = 0;
	int          n_compared = 0;
	// {skip expected, raw bits 10:0 expected, event stimulus}
	logic [23:0] rows [11] = '{24'h004001, 24'h044043, 24'h006007, 24'h00600b, 24'h006033, 24'h004023,
		24'h904880, 24'h104080, 24'h008100, 24'h088300, 24'h208400};
	// {offset, reset value}; the last one is unmapped
	logic [43:0] rrows [8] = '{44'h000_00000000, 44'h024_00000000, 44'h014_ffffff00, 44'h04c_00070008,
		44'h064_00ffffff, 44'h048_00000000, 44'h050_00000000, 44'h0f0_00000000};

	// host clock and an unrelated card-domain clock
	always #4 clk = ~clk;
	initial begin
		#2.7;
		forever #16 cclk = ~cclk;
	end

	sdmmc_bus_events i_dut (
		.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .int_out(int_out), .dma_req(dma_req),
		.card_present_n(card_present_n), .cclk(cclk), .xfer_active(xfer_active),
		.xfer_write(xfer_write), .cmd_done_evt(ev[0]), .cmd_has_data(ev[11]), .resp_done(ev[1]),
		.resp_tx_bit(ev[2]), .resp_end_bit(!ev[3]), .resp_check_index(ev[4]),
		.resp_index(ev[5] ? 6'h05 : 6'h11), .sent_index(6'h11), .resp_crc_bad(ev[6]),
		.resp_timeout_evt(ev[7]), .data_done_evt(ev[8]), .data_crc_bad(ev[9]),
		.data_read_timeout_evt(ev[10]), .card_push(card_push), .card_wdata(card_wdata),
		.card_pop(card_pop), .card_rdata(card_rdata), .card_fifo_empty(card_fifo_empty),
		.card_fifo_full(card_fifo_full), .card_clk_stop(card_clk_stop), .skip_data(skip_data));

	card_side_model i_card (
		.cclk(cclk), .card_fifo_empty(card_fifo_empty), .card_fifo_full(card_fifo_full),
		.card_clk_stop(card_clk_stop), .skip_data(skip_data), .card_rdata(card_rdata),
		.xfer_active(xfer_active), .xfer_write(xfer_write), .card_push(card_push),
		.card_pop(card_pop), .card_wdata(card_wdata), .ev(ev));

	// comparison and verdict helpers
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// register bus cycles: strobe held over exactly one taking edge
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		#1 reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		@(posedge clk);
		#1 reg_wr = 1'b0;
	endtask

	task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk);
		#1 reg_rd = 1'b1;
		reg_addr = a;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		d = reg_rdata;
		chk(nm, d & m, e);
	endtask

	// bounded wait on the card clock halt flag
	task automatic wstop(input logic v);
		for (int i = 0; i < 300; i++) begin
			if (card_clk_stop === v)
				return;
			@(posedge clk);
		end
		chk("clk_stop_wait", 32'h1, 32'h0);
		conclude();
	endtask

	// reset long enough for the card domain to see it
	task automatic do_reset();
		@(posedge clk);
		#1 srst = 1'b1;
		repeat (5) @(posedge cclk);
		@(posedge clk);
		#1 srst = 1'b0;
		repeat (3) @(posedge cclk);
	endtask

	// main sequence
	initial begin
		do_reset();
		foreach (rows[i]) begin
			wr(12'h044, 32'hffff_ffff);
			i_card.pulse(rows[i][11:0]);
			repeat (12) @(posedge clk);
			rc("raw_status", 12'h044, 32'h0000_07ce, {21'h0, rows[i][22:12]});
			chk("skip_data", {31'h0, i_card.skip_seen}, {31'h0, rows[i][23]});
		end
		$display("event table done");
		do_reset();
		foreach (rrows[i])
			rc("reset_value", rrows[i][43:32], 32'hffff_ffff, rrows[i][31:0]);
		$display("reset values done");
		wr(12'h044, 32'hffff_ffff);
		wr(12'h024, 32'h0000_0004);
		wr(12'h000, 32'h0000_0010);
		i_card.pulse(12'h001);
		repeat (12) @(posedge clk);
		chk("int_set", {31'h0, int_out}, 32'h1);
		wr(12'h044, 32'h0000_0000);
		rc("raw_w0", 12'h044, 32'h0000_0004, 32'h0000_0004);
		wr(12'h024, 32'h0000_0000);
		repeat (3) @(posedge clk);
		chk("int_masked", {31'h0, int_out}, 32'h0);
		wr(12'h024, 32'h0000_0004);
		wr(12'h000, 32'h0000_0000);
		repeat (3) @(posedge clk);
		chk("int_disabled", {31'h0, int_out}, 32'h0);
		wr(12'h000, 32'h0000_0010);
		wr(12'h044, 32'h0000_0004);
		repeat (3) @(posedge clk);
		chk("int_cleared", {31'h0, int_out}, 32'h0);
		$display("interrupt done");
		// card read fills the fifo until the card clock halts, host drains it
		wr(12'h000, 32'h0000_0020);
		wr(12'h014, 32'h0000_0400);
		wr(12'h044, 32'hffff_ffff);
		i_card.xfer(1'b1, 1'b0);
		i_card.stream(1'b0, 40);
		wstop(1'b1);
		repeat (20) @(posedge clk);
		rc("hto_rx_fifo_request", 12'h044, 32'h0000_0420, 32'h0000_0420);
		chk("dma_rx", {31'h0, dma_req}, 32'h1);
		rc("fill_count", 12'h048, 32'hfffe_0000, 32'h0020_0000);
		for (int k = 0; k < 16; k++) begin
			rc("fifo_word", 12'h200, 32'hffff_ffff, {16'ha5a5, k[15:0]});
			if (k == 1)
				wstop(1'b0);
		end
		repeat (10) @(posedge clk);
		chk("dma_rx_idle", {31'h0, dma_req}, 32'h0);
		wr(12'h044, 32'h0000_0020);
		rc("rx_fifo_request_clear", 12'h044, 32'h0000_0020, 32'h0000_0000);
		i_card.xfer(1'b0, 1'b0);
		$display("read stream done");
		// card write starts on an empty fifo, host supplies two words
		wr(12'h044, 32'hffff_ffff);
		i_card.xfer(1'b1, 1'b1);
		wstop(1'b1);
		repeat (10) @(posedge clk);
		rc("tx_fifo_request", 12'h044, 32'h0000_0010, 32'h0000_0010);
		chk("dma_tx", {31'h0, dma_req}, 32'h1);
		wr(12'h200, 32'hc0de_0001);
		wr(12'h204, 32'hc0de_0002);
		i_card.stream(1'b1, 24);
		chk("pop_count", 32'(i_card.rx_q.size()), 32'h2);
		foreach (i_card.rx_q[i])
			chk("pop_word", i_card.rx_q[i], 32'hc0de_0001 + 32'(i));
		wstop(1'b1);
		i_card.xfer(1'b0, 1'b0);
		$display("write stream done");
		// card insertion with a short debounce gives exactly one event
		wr(12'h064, 32'h0000_0004);
		wr(12'h044, 32'hffff_ffff);
		@(posedge clk);
		#1 card_present_n = 1'b0;
		repeat (30) @(posedge clk);
		rc("cdt", 12'h044, 32'h0000_0001, 32'h0000_0001);
		rc("card_state", 12'h050, 32'h0000_0001, 32'h0000_0001);
		wr(12'h044, 32'h0000_0001);
		repeat (30) @(posedge clk);
		rc("cdt_once", 12'h044, 32'h0000_0001, 32'h0000_0000);
		$display("card detect done");
		conclude();
	end
endmodule
